// ===== csf_pkg.sv
// Notes on behaviour
// - Every decoder event owns a status flag; flags are raised at FIFO output.
// - Decoder flags block start when the next word to read opens a block.
// - Decoder flags missing sync at block start when no sync preceded it.
// - Decoder flags bad length when the previous block was not 2352 bytes.
// - Decoder flags CRC failure at block start when the previous block failed.
// - Encoder order is CRC insert, then scramble, then byte swap.
// - Control register fields steer CRC mode, scrambling and swap.
// - Encoder starts a block on the word after the sync pattern.
// - Encoder also starts a block 2352 bytes after the previous start.
// - Encoder block start event fires when that block's first word leaves.
// - Encoder flags missing sync when the block start came from the count.
// - Encoder flags bad length when the previous block was not 2352 bytes.
// - Only the receive FIFO two and transmit FIFO three drive DMA requests.
// - Select bit zero routes transmit FIFO empty onto that request line.
// - Select bit one routes transmit FIFO empty onto that request line.
// - Without sync a block starts one block length after the previous.
// - Inserted CRC replaces whatever software wrote in the CRC slot.
package csf_pkg;

  // ********************
  // Framing constants
  // ********************
  localparam int BLOCK_BYTES = 2352;
  localparam int WORD_BYTES = 4;
  localparam logic [9:0] BLOCK_WORDS = 10'(BLOCK_BYTES / WORD_BYTES);
  localparam logic [31:0] SYNC_W0 = 32'h00ffffff;
  localparam logic [31:0] SYNC_W1 = 32'hffffffff;
  localparam logic [31:0] SYNC_W2 = 32'hffffff00;
  localparam logic [9:0] EDC_FIRST_M1 = 10'h000;
  localparam logic [9:0] EDC_FIRST_M2 = 10'h004;
  localparam logic [9:0] EDC_SLOT_M1 = 10'h204;
  localparam logic [9:0] EDC_SLOT_F1 = 10'h206;
  localparam logic [9:0] EDC_SLOT_F2 = 10'h24b;
  localparam logic [31:0] EDC_POLY = 32'hd8018001;
  localparam logic [31:0] EDC_INIT = 32'h00000000;
  localparam logic [14:0] SCR_SEED = 15'h0001;
  localparam logic [9:0] SCR_END = 10'h249;

  // ********************
  // Register map (word indices)
  // ********************
  localparam logic [7:0] IDX_CTRL = 8'h90;
  localparam logic [7:0] IDX_STAT = 8'h91;
  localparam logic [7:0] IDX_MASK = 8'h92;
  localparam logic [7:0] IDX_DMA = 8'h9f;
  localparam int CTL_W = 9;
  localparam int CTL_ENC_MODE = 0;
  localparam int CTL_ENC_SCR = 2;
  localparam int CTL_ENC_SYNC = 3;
  localparam int CTL_ENC_SWAP = 4;
  localparam int CTL_DEC_MODE = 6;
  localparam int CTL_DEC_SYNC = 8;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int ST_W = 7;
  localparam int ST_DEC_START = 0;
  localparam int ST_DEC_SYNC_MISSING_FLAG = 1;
  localparam int ST_DEC_BADLEN = 2;
  localparam int ST_DEC_CRC = 3;
  localparam int ST_ENC_START = 4;
  localparam int ST_ENC_SYNC_MISSING_FLAG = 5;
  localparam int ST_ENC_BADLEN = 6;
  localparam int DMA_W = 2;
  localparam int DMA_REQ0_BIT = 0;
  localparam int DMA_REQ1_BIT = 1;

  typedef enum logic [1:0] {NO_CRC, MODE1, M2F1, M2F2} csf_mode_e;
  typedef enum logic [1:0] {SW_NONE, SW_HALF, SW_BYTE, SW_REV} csf_swap_e;

  // First word covered by the CRC
  function automatic logic [9:0] csf_edc_first(input logic [1:0] m);
    return (m == MODE1) ? EDC_FIRST_M1 : EDC_FIRST_M2;
  endfunction

  // Word index that carries the CRC
  function automatic logic [9:0] csf_edc_slot(input logic [1:0] m);
    return (m == MODE1) ? EDC_SLOT_M1 : (m == M2F1) ? EDC_SLOT_F1 : EDC_SLOT_F2;
  endfunction

  // Reflected CRC over one word, high byte first
  function automatic logic [31:0] csf_crc_word(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c;
    for (int b = 3; b >= 0; b--)
    begin
      r[7:0] = r[7:0] ^ w[b*8 +: 8];
      for (int i = 0; i < 8; i++)
        r = r[0] ? ((r >> 1) ^ EDC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Scrambler: returns {next lfsr, 32 key bits}
  function automatic logic [46:0] csf_scr_step(input logic [14:0] s);
    logic [14:0] l;
    logic [31:0] k;
    l = s;
    k = '0;
    for (int b = 3; b >= 0; b--)
      for (int i = 0; i < 8; i++)
      begin
        k[b*8+i] = l[0];
        l = {l[0] ^ l[1], l[14:1]};
      end
    return {l, k};
  endfunction

  // Byte swap of one longword
  function automatic logic [31:0] csf_swap(input logic [31:0] w, input logic [1:0] s);
    unique case (s)
      SW_NONE: return w;
      SW_HALF: return {w[15:0], w[31:16]};
      SW_BYTE: return {w[23:16], w[31:24], w[7:0], w[15:8]};
      SW_REV: return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endcase
  endfunction

endpackage

// ===== csf_encoder.sv
module csf_encoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic scr_en,
  input wire logic sync_en,
  input wire logic [1:0] swap_sel,
  input wire logic [31:0] in_word,
  input wire logic in_valid,
  output logic in_ready,
  output logic [31:0] out_word,
  output logic out_valid,
  input wire logic out_ready,
  output logic ev_start,
  output logic ev_sync_missing_flag,
  output logic ev_badlen
);
  typedef struct packed {
    logic [9:0] cnt;
    logic pend;
    logic pend_sync_missing_flag;
    logic pend_bad;
    logic [31:0] h0;
    logic [31:0] h1;
    logic [31:0] crc;
    logic [14:0] lfsr;
    logic [31:0] word;
    logic full;
    logic rdy;
    logic first;
    logic sync_missing_flag;
    logic bad;
    logic ev_s;
    logic ev_n;
    logic ev_b;
  } csf_enc_s;

  csf_enc_s st;
  csf_enc_s next_st;
  logic [9:0] idx;
  logic [31:0] crc_now;
  logic [46:0] scr;
  logic take;

  // Position of the incoming word and running CRC; a pending start restarts both
  assign idx = st.pend ? '0 : st.cnt;
  assign crc_now = st.pend ? csf_pkg::EDC_INIT : st.crc;
  assign scr = csf_pkg::csf_scr_step(st.pend ? csf_pkg::SCR_SEED : st.lfsr);
  assign take = in_valid && st.rdy;

  // One word held at a time: ready stays a flop at the cost of half rate
  always_comb
  begin
    logic [31:0] w;
    w = in_word;
    next_st = st;
    next_st.ev_s = 1'b0;
    next_st.ev_n = 1'b0;
    next_st.ev_b = 1'b0;
    if (mode != csf_pkg::NO_CRC && idx == csf_pkg::csf_edc_slot(mode))
      w = crc_now;
    if (scr_en && idx < csf_pkg::SCR_END)
      w = w ^ scr[31:0];
    if (st.full && out_ready)
    begin
      next_st.full = 1'b0;
      next_st.rdy = 1'b1;
      next_st.ev_s = st.first;
      next_st.ev_n = st.first && st.sync_missing_flag;
      next_st.ev_b = st.first && st.bad;
    end
    if (take)
    begin
      next_st.full = 1'b1;
      next_st.rdy = 1'b0;
      next_st.word = csf_pkg::csf_swap(w, swap_sel);
      next_st.first = st.pend;
      next_st.sync_missing_flag = st.pend_sync_missing_flag;
      next_st.bad = st.pend_bad;
      if (idx >= csf_pkg::csf_edc_first(mode) && idx < csf_pkg::csf_edc_slot(mode))
        next_st.crc = csf_pkg::csf_crc_word(crc_now, in_word);
      else
        next_st.crc = crc_now;
      next_st.lfsr = scr[46:32];
      next_st.h0 = st.h1;
      next_st.h1 = in_word;
      next_st.cnt = idx + 10'h001;
      next_st.pend = 1'b0;
      if (sync_en && st.h0 == csf_pkg::SYNC_W0 && st.h1 == csf_pkg::SYNC_W1
          && in_word == csf_pkg::SYNC_W2)
      begin
        next_st.pend = 1'b1;
        next_st.pend_sync_missing_flag = 1'b0;
        next_st.pend_bad = (idx + 10'h001) != csf_pkg::BLOCK_WORDS;
      end
      else if ((idx + 10'h001) == csf_pkg::BLOCK_WORDS)
      begin
        next_st.pend = 1'b1;
        next_st.pend_sync_missing_flag = 1'b1;
        next_st.pend_bad = 1'b0;
      end
    end
  end

  // State register; the first word after reset opens a block with no sync seen
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '{pend: 1'b1, pend_sync_missing_flag: 1'b1, rdy: 1'b1, lfsr: csf_pkg::SCR_SEED, default: '0};
    else
      st <= next_st;
  end

  assign in_ready = st.rdy;
  assign out_word = st.word;
  assign out_valid = st.full;
  assign ev_start = st.ev_s;
  assign ev_sync_missing_flag = st.ev_n;
  assign ev_badlen = st.ev_b;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_enc_count_wrap: assert property (
    take && !st.pend && idx == csf_pkg::BLOCK_WORDS - 10'h001 |=> st.pend)
    else $error("count did not open a new block");
  a_enc_crc_slot: assert property (
    take && mode != csf_pkg::NO_CRC && idx == csf_pkg::csf_edc_slot(mode) && !scr_en
    && swap_sel == csf_pkg::SW_NONE |=> out_word == $past(crc_now))
    else $error("crc slot not overwritten");
  a_enc_start_event: assert property (
    ev_start |-> $past(st.full && out_ready && st.first))
    else $error("start event without first word leaving");
endmodule

// ===== csf_framer.sv
module csf_framer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] rx_head_word,
  input wire logic rx_head_valid,
  input wire logic rx_pop,
  input wire logic rx_fifo_two_full,
  input wire logic [31:0] tx_in_word,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output logic [31:0] tx_out_word,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  input wire logic tx_fifo_three_empty,
  output logic dma_request_zero,
  output logic dma_request_one,
  output logic irq
);

  // ********************
  // State
  // ********************
  typedef struct packed {
    logic [csf_pkg::CTL_W-1:0] ctrl;
    logic [csf_pkg::ST_W-1:0] status;
    logic [csf_pkg::ST_W-1:0] mask;
    logic [csf_pkg::DMA_W-1:0] dsel;
    logic wait_req;
    logic [31:0] rdata;
    logic irq;
    logic dreq0;
    logic dreq1;
    logic [9:0] cnt;
    logic pend;
    logic announced;
    logic pend_sync_missing_flag;
    logic pend_bad;
    logic pend_crc;
    logic [31:0] h0;
    logic [31:0] h1;
    logic [31:0] crc;
    logic crc_bad;
  } csf_top_s;

  csf_top_s st;
  csf_top_s next_st;

  logic enc_start;
  logic enc_sync_missing_flag;
  logic enc_badlen;
  logic [1:0] dec_mode;
  logic dec_sync_en;
  logic pop;
  logic [9:0] d_idx;
  logic [31:0] d_crc;
  logic d_sync_hit;
  logic d_at_slot;
  logic [csf_pkg::ST_W-1:0] ev_set;
  logic [csf_pkg::ST_W-1:0] ev_clr;
  logic [31:0] be_mask;
  logic wr_now;

  // ********************
  // Helpers
  // ********************

  // Byte-lane mask from Avalon byte enables
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{be[i]}};
    return m;
  endfunction

  // Register read decode; unmapped indices read as zero
  function automatic logic [31:0] reg_read(input csf_top_s s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      csf_pkg::IDX_CTRL: r[csf_pkg::CTL_W-1:0] = s.ctrl;
      csf_pkg::IDX_STAT: r[csf_pkg::ST_W-1:0] = s.status;
      csf_pkg::IDX_MASK: r[csf_pkg::ST_W-1:0] = s.mask;
      csf_pkg::IDX_DMA: r[csf_pkg::DMA_W-1:0] = s.dsel;
      default: r = '0;
    endcase
    return r;
  endfunction

  // ********************
  // Encoder path
  // ********************

  // Control fields steer the encoder stages directly
  csf_encoder u_enc (
    .clk(clk),
    .rst(rst),
    .mode(st.ctrl[csf_pkg::CTL_ENC_MODE +: 2]),
    .scr_en(st.ctrl[csf_pkg::CTL_ENC_SCR]),
    .sync_en(st.ctrl[csf_pkg::CTL_ENC_SYNC]),
    .swap_sel(st.ctrl[csf_pkg::CTL_ENC_SWAP +: 2]),
    .in_word(tx_in_word),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .out_word(tx_out_word),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .ev_start(enc_start),
    .ev_sync_missing_flag(enc_sync_missing_flag),
    .ev_badlen(enc_badlen)
  );

  // ********************
  // Decoder framing
  // ********************

  // The decoder watches the receive FIFO head, so events line up with reads
  assign dec_mode = st.ctrl[csf_pkg::CTL_DEC_MODE +: 2];
  assign dec_sync_en = st.ctrl[csf_pkg::CTL_DEC_SYNC];
  assign pop = rx_pop && rx_head_valid;
  assign d_idx = st.pend ? '0 : st.cnt;
  assign d_crc = st.pend ? csf_pkg::EDC_INIT : st.crc;
  assign d_at_slot = dec_mode != csf_pkg::NO_CRC && d_idx == csf_pkg::csf_edc_slot(dec_mode);

  // Sync is three whole words ending with the one being read
  assign d_sync_hit = dec_sync_en && st.h0 == csf_pkg::SYNC_W0
    && st.h1 == csf_pkg::SYNC_W1 && rx_head_word == csf_pkg::SYNC_W2;

  // ********************
  // Event collection
  // ********************

  // Decoder events fire once, when the opening word shows at the FIFO head
  always_comb
  begin
    ev_set = '0;
    if (st.pend && rx_head_valid && !st.announced)
    begin
      ev_set[csf_pkg::ST_DEC_START] = 1'b1;
      ev_set[csf_pkg::ST_DEC_SYNC_MISSING_FLAG] = st.pend_sync_missing_flag;
      ev_set[csf_pkg::ST_DEC_BADLEN] = st.pend_bad;
      ev_set[csf_pkg::ST_DEC_CRC] = st.pend_crc;
    end
    ev_set[csf_pkg::ST_ENC_START] = enc_start;
    ev_set[csf_pkg::ST_ENC_SYNC_MISSING_FLAG] = enc_sync_missing_flag;
    ev_set[csf_pkg::ST_ENC_BADLEN] = enc_badlen;
  end

  // ********************
  // Bus decode
  // ********************

  // A write lands at the edge where the master sees waitrequest low
  assign wr_now = avs_write && !st.wait_req;
  assign be_mask = lane_mask(avs_byteenable);
  assign ev_clr = (wr_now && avs_address == csf_pkg::IDX_STAT)
    ? avs_writedata[csf_pkg::ST_W-1:0] & be_mask[csf_pkg::ST_W-1:0] : '0;

  // ********************
  // Next state
  // ********************
  always_comb
  begin
    logic [31:0] wv;
    logic blk_crc_bad;
    wv = avs_writedata & be_mask;
    blk_crc_bad = 1'b0;
    next_st = st;

    // One wait state per access keeps read data and write timing fixed
    if ((avs_read || avs_write) && st.wait_req)
    begin
      next_st.wait_req = 1'b0;
      next_st.rdata = reg_read(st, avs_address);
    end
    else
    begin
      next_st.wait_req = 1'b1;
    end

    // Register writes honour byte lanes
    if (wr_now)
    begin
      unique case (avs_address)
        csf_pkg::IDX_CTRL:
          next_st.ctrl = (st.ctrl & ~be_mask[csf_pkg::CTL_W-1:0])
            | wv[csf_pkg::CTL_W-1:0];
        csf_pkg::IDX_MASK:
          next_st.mask = (st.mask & ~be_mask[csf_pkg::ST_W-1:0])
            | wv[csf_pkg::ST_W-1:0];
        csf_pkg::IDX_DMA:
          next_st.dsel = (st.dsel & ~be_mask[csf_pkg::DMA_W-1:0])
            | wv[csf_pkg::DMA_W-1:0];
        default:
          next_st.ctrl = st.ctrl;
      endcase
    end

    // Sticky status: a set in the clearing cycle survives
    next_st.status = (st.status & ~ev_clr) | ev_set;
    next_st.irq = |(next_st.status & next_st.mask);

    // DMA lines are registered, so each drops one cycle after its cause
    next_st.dreq0 = st.dsel[csf_pkg::DMA_REQ0_BIT]
      ? tx_fifo_three_empty : rx_fifo_two_full;
    next_st.dreq1 = st.dsel[csf_pkg::DMA_REQ1_BIT]
      ? tx_fifo_three_empty : rx_fifo_two_full;

    // Mark the head as announced so the flags fire only once
    if (st.pend && rx_head_valid)
    begin
      next_st.announced = 1'b1;
    end

    // Word consumed from the FIFO head
    if (pop)
    begin
      if (d_idx >= csf_pkg::csf_edc_first(dec_mode)
          && d_idx < csf_pkg::csf_edc_slot(dec_mode))
        next_st.crc = csf_pkg::csf_crc_word(d_crc, rx_head_word);
      else
        next_st.crc = d_crc;
      blk_crc_bad = (st.pend ? 1'b0 : st.crc_bad)
        | (d_at_slot && rx_head_word != d_crc);
      next_st.crc_bad = blk_crc_bad;
      next_st.h0 = st.h1;
      next_st.h1 = rx_head_word;
      next_st.cnt = d_idx + 10'h001;
      next_st.pend = 1'b0;
      next_st.announced = 1'b0;
      if (d_sync_hit)
      begin
        next_st.pend = 1'b1;
        next_st.pend_sync_missing_flag = 1'b0;
        next_st.pend_bad = (d_idx + 10'h001) != csf_pkg::BLOCK_WORDS;
        next_st.pend_crc = blk_crc_bad;
      end
      else if ((d_idx + 10'h001) == csf_pkg::BLOCK_WORDS)
      begin
        next_st.pend = 1'b1;
        next_st.pend_sync_missing_flag = 1'b1;
        next_st.pend_bad = 1'b0;
        next_st.pend_crc = blk_crc_bad;
      end
    end
  end

  // ********************
  // State register
  // ********************

  // First word after reset opens a block that had no sync in front of it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '{ctrl: csf_pkg::CTRL_RST, wait_req: 1'b1, pend: 1'b1,
        pend_sync_missing_flag: 1'b1, default: '0};
    else
      st <= next_st;
  end

  // ********************
  // Outputs
  // ********************
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wait_req;
  assign dma_request_zero = st.dreq0;
  assign dma_request_one = st.dreq1;
  assign irq = st.irq;

  // ********************
  // Checks
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_dma_zero_rx: assert property (
    !st.dsel[csf_pkg::DMA_REQ0_BIT] && rx_fifo_two_full |=> dma_request_zero)
    else $error("request zero missed full receive fifo");

  a_dma_one_tx: assert property (
    st.dsel[csf_pkg::DMA_REQ1_BIT] && tx_fifo_three_empty |=> dma_request_one)
    else $error("request one missed empty transmit fifo");

  a_dma_zero_drop: assert property (
    !st.dsel[csf_pkg::DMA_REQ0_BIT] && !rx_fifo_two_full |=> !dma_request_zero)
    else $error("request zero held without cause");

  a_irq_follows_status: assert property (
    irq == |(st.status & st.mask))
    else $error("interrupt disagrees with masked status");

  a_dec_start_head: assert property (
    $rose(st.status[csf_pkg::ST_DEC_START]) |-> $past(st.pend && rx_head_valid))
    else $error("decoder start flag without block head");

  a_dec_sync_missing_flag_cause: assert property (
    $rose(st.status[csf_pkg::ST_DEC_SYNC_MISSING_FLAG]) |-> $past(st.pend && st.pend_sync_missing_flag))
    else $error("decoder missing sync flag without cause");

  a_dec_badlen_cause: assert property (
    $rose(st.status[csf_pkg::ST_DEC_BADLEN]) |-> $past(st.pend && st.pend_bad))
    else $error("decoder bad length flag without cause");

  a_dec_period: assert property (
    pop && !st.pend && d_idx == csf_pkg::BLOCK_WORDS - 10'h001 |=> st.pend)
    else $error("decoder missed counted block start");

  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not in one wait state");

  // Request lines follow the selected condition one cycle late, both ways
  a_dma_one_rx: assert property (
    !st.dsel[csf_pkg::DMA_REQ1_BIT] && rx_fifo_two_full |=> dma_request_one)
    else $error("request one missed full receive fifo");

  a_dma_zero_tx: assert property (
    st.dsel[csf_pkg::DMA_REQ0_BIT] && tx_fifo_three_empty |=> dma_request_zero)
    else $error("request zero missed empty transmit fifo");

  a_dma_one_drop: assert property (
    st.dsel[csf_pkg::DMA_REQ1_BIT] && !tx_fifo_three_empty |=> !dma_request_one)
    else $error("request one held without cause");

  a_dec_crc_cause: assert property (
    $rose(st.status[csf_pkg::ST_DEC_CRC]) |-> $past(st.pend && st.pend_crc))
    else $error("decoder crc flag without cause");

  a_status_set_wins: assert property (
    (|ev_set) |=> (st.status & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");

  a_ctrl_write_lands: assert property (
    wr_now && avs_address == csf_pkg::IDX_CTRL && avs_byteenable == 4'hf
    |=> st.ctrl == $past(avs_writedata[csf_pkg::CTL_W-1:0]))
    else $error("control write did not land");

  c_dec_sync_start: cover property (pop && d_sync_hit ##[1:20] st.status[csf_pkg::ST_DEC_START]);
  c_dec_crc_fail: cover property ($rose(st.status[csf_pkg::ST_DEC_CRC]));
  c_enc_start: cover property (enc_start && !enc_sync_missing_flag);
  c_dma_tx: cover property (dma_request_one && st.dsel[csf_pkg::DMA_REQ1_BIT]);

endmodule

// ===== csf_far_model.sv
module csf_far_model (
  input wire logic clk,
  input wire logic rst,
  output logic [31:0] rx_head_word,
  output logic rx_head_valid,
  output logic rx_pop,
  input wire logic [31:0] tx_out_word,
  input wire logic tx_out_valid,
  output logic tx_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rxq[$];
  logic [31:0] tx_last = 32'h0;
  int tx_n = 0;
  // ****************************
  // Receive head and transmit sink
  // ****************************
  // Receive head pops at once; the transmit sink stalls every other cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_head_valid <= 1'b0;
      rx_pop <= 1'b0;
      rx_head_word <= 32'h0;
      tx_out_ready <= 1'b0;
    end
    else
    begin
      if (rx_head_valid && rx_pop)
        void'(rxq.pop_front());
      rx_head_valid <= (rxq.size() > 0);
      rx_pop <= (rxq.size() > 0);
      // An empty head toggles so that a stale word can never pass as data
      rx_head_word <= (rxq.size() > 0) ? rxq[0] : ~rx_head_word;
      if (tx_out_valid && tx_out_ready)
      begin
        tx_last = tx_out_word;
        tx_n++;
      end
      tx_out_ready <= ~tx_out_ready;
    end
  end
endmodule

// ===== cd_sector_framing_dma_req_test.sv
module cd_sector_framing_dma_req_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, rx_head_valid, rx_pop;
  logic rx_fifo_two_full, tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic tx_fifo_three_empty, dma_request_zero, dma_request_one, irq;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rx_head_word, tx_in_word, tx_out_word, q;
  logic [31:0] swp[4] = '{32'h11223344, 32'h33441122, 32'h22114433, 32'h44332211};
  int bad_count = 0;
  int compares = 0;

  csf_framer DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_head_word(rx_head_word), .rx_head_valid(rx_head_valid), .rx_pop(rx_pop),
    .rx_fifo_two_full(rx_fifo_two_full), .tx_in_word(tx_in_word), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_out_word(tx_out_word), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .tx_fifo_three_empty(tx_fifo_three_empty),
    .dma_request_zero(dma_request_zero), .dma_request_one(dma_request_one), .irq(irq));
  csf_far_model far (.clk(clk), .rst(rst), .rx_head_word(rx_head_word),
    .rx_head_valid(rx_head_valid), .rx_pop(rx_pop), .tx_out_word(tx_out_word),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready));

  // ****************************
  // Clock, tasks and verdict
  // ****************************
  // Clock of 5 ns period
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task give_verdict;
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; an edge passes first so strobes never toggle twice at once
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask

  task clear_status;
    bus(1'b1, csf_pkg::IDX_STAT, 32'h0000007f);
  endtask

  // Offer one word to the encoder and wait until the sink has taken it
  task send_tx(input logic [31:0] w);
    int n, t0;
    n = 0;
    t0 = far.tx_n;
    @(posedge clk);
    tx_in_word <= w;
    tx_in_valid <= 1'b1;
    @(posedge clk);
    while (tx_in_ready !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    tx_in_valid <= 1'b0;
    while (far.tx_n == t0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 100)
      bad_count++;
  endtask

  // Let the receive queue drain, then allow the flags time to land
  task wait_rx;
    int n;
    n = 0;
    while (far.rxq.size() != 0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
      bad_count++;
    repeat (4) @(posedge clk);
  endtask

  // Watchdog at 20000 cycles, well beyond the expected run of about 6000 cycles
  initial
  begin
    #100000;
    bad_count++;
    give_verdict;
  end

  // ****************************
  // Test sequence
  // ****************************
  initial
  begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    rx_fifo_two_full = 1'b0;
    tx_fifo_three_empty = 1'b0;
    tx_in_valid = 1'b0;
    tx_in_word = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(csf_pkg::IDX_CTRL, 32'h0, "ctrl reset");
    rd(csf_pkg::IDX_MASK, 32'h0, "mask reset");
    rd(csf_pkg::IDX_DMA, 32'h0, "dma select reset");
    rd(csf_pkg::IDX_STAT, 32'h0, "status reset");
    bus(1'b1, 8'h10, 32'hffffffff);
    rd(8'h10, 32'h0, "unmapped");
    // Decoder and encoder sync recognition on
    bus(1'b1, csf_pkg::IDX_CTRL, 32'h00000108);
    rd(csf_pkg::IDX_CTRL, 32'h00000108, "ctrl readback");
    far.rxq.push_back(32'h12345678);
    wait_rx;
    rd(csf_pkg::IDX_STAT, 32'h3, "dec first block");
    bus(1'b1, csf_pkg::IDX_MASK, 32'h1);
    rd(csf_pkg::IDX_STAT, 32'h3, "status kept");
    check("irq on", {31'h0, irq}, 32'h1);
    clear_status;
    rd(csf_pkg::IDX_STAT, 32'h0, "status cleared");
    check("irq off", {31'h0, irq}, 32'h0);
    // Short block closed by a sync
    far.rxq.push_back(csf_pkg::SYNC_W0);
    far.rxq.push_back(csf_pkg::SYNC_W1);
    far.rxq.push_back(csf_pkg::SYNC_W2);
    far.rxq.push_back(32'h0badf00d);
    wait_rx;
    rd(csf_pkg::IDX_STAT, 32'h5, "dec sync start");
    clear_status;
    // Without sync the next start falls 588 words later
    for (int i = 0; i < 588; i++)
      far.rxq.push_back(32'h100 + i);
    wait_rx;
    rd(csf_pkg::IDX_STAT, 32'h3, "dec counted start");
    clear_status;
    // Every swap mode on the encoder path
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, csf_pkg::IDX_CTRL, 32'h108 | (32'(s) << 4));
      send_tx(32'h11223344);
      check("tx swap", far.tx_last, swp[s]);
    end
    rd(csf_pkg::IDX_STAT, 32'h30, "enc first block");
    clear_status;
    send_tx(csf_pkg::SYNC_W0);
    send_tx(csf_pkg::SYNC_W1);
    send_tx(csf_pkg::SYNC_W2);
    send_tx(32'h0badf00d);
    check("tx after sync", far.tx_last, 32'h0df0ad0b);
    rd(csf_pkg::IDX_STAT, 32'h50, "enc sync start");
    clear_status;
    for (int i = 0; i < 588; i++)
    begin
      if (i == 587)
        rd(csf_pkg::IDX_STAT, 32'h0, "enc no early start");
      send_tx(32'h100 + i);
    end
    rd(csf_pkg::IDX_STAT, 32'h30, "enc counted start");
    clear_status;
    // A zero block has a zero mode 1 CRC, so a nonzero slot word fails
    bus(1'b1, csf_pkg::IDX_CTRL, 32'h00000140);
    far.rxq.push_back(csf_pkg::SYNC_W0);
    far.rxq.push_back(csf_pkg::SYNC_W1);
    far.rxq.push_back(csf_pkg::SYNC_W2);
    for (int i = 0; i < 589; i++)
      far.rxq.push_back((i == 516) ? 32'h1 : 32'h0);
    wait_rx;
    rd(csf_pkg::IDX_STAT, 32'hf, "dec crc fail");
    // The encoder must lay that zero CRC over the word written at the slot
    bus(1'b1, csf_pkg::IDX_CTRL, 32'h00000149);
    send_tx(csf_pkg::SYNC_W0);
    send_tx(csf_pkg::SYNC_W1);
    send_tx(csf_pkg::SYNC_W2);
    for (int i = 0; i < 517; i++)
      send_tx((i == 516) ? 32'h5a : 32'h0);
    check("tx crc slot", far.tx_last, 32'h0);
    // Every select value against every FIFO condition
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, csf_pkg::IDX_DMA, 32'(s));
      for (int c = 0; c < 4; c++)
      begin
        @(posedge clk);
        rx_fifo_two_full <= c[0];
        tx_fifo_three_empty <= c[1];
        repeat (3) @(posedge clk);
        check("req zero", {31'h0, dma_request_zero}, s[0] ? c[1] : c[0]);
        check("req one", {31'h0, dma_request_one}, s[1] ? c[1] : c[0]);
      end
    end
    rd(csf_pkg::IDX_DMA, 32'h3, "dma select readback");
    give_verdict;
  end
endmodule
